// [common/flash_seq_if.sv]
// Interface joining the CPU-side end to the flash sequencer.
`timescale 1ns/100ps
`default_nettype none
interface flash_seq_if #(parameter int PTR_W = 16);
  logic ctrl_we;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm_strobe;
  logic [PTR_W-1:0] pointer;
  logic [15:0] data_pair;
  logic cpu_halt;
  modport device (input ctrl_we, ctrl_wdata, spm_strobe, pointer, data_pair, output ctrl_rdata, cpu_halt);
  modport cpu (output ctrl_we, ctrl_wdata, spm_strobe, pointer, data_pair, input ctrl_rdata, cpu_halt);
endinterface
`default_nettype wire

// [common/flash_seq_pkg.sv]
// Shared constants for the flash self-program sequencer and its CPU-side end.
package flash_seq_pkg;
  // Control register bit positions.
  localparam int PROGRAM_ENABLE_POS = 0;
  localparam int PAGE_ERASE_POS = 1;
  localparam int PAGE_WRITE_POS = 2;
  localparam int CLEAR_BUFFER_POS = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h17;
  // Control patterns.
  localparam logic [7:0] PAT_LOAD = 8'h01;
  localparam logic [7:0] PAT_ERASE = 8'h03;
  localparam logic [7:0] PAT_WRITE = 8'h05;
  // Arming window in clock cycles.
  localparam int ARM_WINDOW = 4;
  // Flash operation time and clock rate.
  localparam int CLOCK_HZ = 10000000;
  localparam int OP_MIN_US = 3700;
  localparam int OP_MAX_US = 4500;
  localparam int OP_CYCLES = (OP_MIN_US * (CLOCK_HZ / 1000000)) + 1;
  // Host command codes.
  localparam logic [1:0] CMD_LOAD = 2'h0;
  localparam logic [1:0] CMD_ERASE = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_CLEAR = 2'h3;
  // Host register offsets.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_POINTER = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
endpackage

// [core/flash_cpu_end.sv]
// CPU-side end: turns software commands into control writes and store strobes.
`timescale 1ns/100ps
`default_nettype none
module flash_cpu_end #(
  parameter int PTR_W = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Software register port.
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Link to the sequencer.
  flash_seq_if.cpu bus
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  state_t state;
  logic [PTR_W-1:0] pointer;
  logic [15:0] data_pair;
  logic [7:0] pattern;
  logic clear_only;

  // Command decode; other commands are dropped while busy.
  wire cmd_wr = wr && addr == flash_seq_pkg::REG_CMD && state == ST_IDLE;
  wire [1:0] cmd = wdata[1:0];
  wire busy = state != ST_IDLE || bus.cpu_halt;
  wire [7:0] cmd_pat = (cmd == flash_seq_pkg::CMD_ERASE) ? flash_seq_pkg::PAT_ERASE :
                       (cmd == flash_seq_pkg::CMD_WRITE) ? flash_seq_pkg::PAT_WRITE :
                       (cmd == flash_seq_pkg::CMD_CLEAR) ? 8'h10 : flash_seq_pkg::PAT_LOAD;

  // Sequence: control write, store strobe next cycle, then wait for halt release.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      pattern <= '0;
      clear_only <= 1'b0;
      bus.ctrl_we <= 1'b0;
      bus.ctrl_wdata <= '0;
      bus.spm_strobe <= 1'b0;
    end
    else
    begin
      bus.ctrl_we <= cmd_wr;
      bus.ctrl_wdata <= cmd_wr ? cmd_pat : bus.ctrl_wdata;
      bus.spm_strobe <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cmd_wr)
          begin
            pattern <= cmd_pat;
            clear_only <= cmd == flash_seq_pkg::CMD_CLEAR;
            state <= ST_ARM;
          end
        end
        ST_ARM:
        begin
          bus.spm_strobe <= !clear_only;
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (!bus.spm_strobe && !bus.cpu_halt)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pointer and data registers held for the sequencer.
  // software keeps page
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pointer <= '0;
      data_pair <= '0;
    end
    else if (wr && addr == flash_seq_pkg::REG_POINTER)
      pointer <= PTR_W'(wdata);
    else if (wr && addr == flash_seq_pkg::REG_DATA)
      data_pair <= wdata;
  end

  assign bus.pointer = pointer;
  assign bus.data_pair = data_pair;

  // Read port, one cycle after the strobe.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdata <= '0;
    else if (rd)
      rdata <= (addr == flash_seq_pkg::REG_POINTER) ? 16'(pointer) :
               (addr == flash_seq_pkg::REG_DATA) ? data_pair :
               (addr == flash_seq_pkg::REG_STATUS) ? {7'h00, busy, bus.ctrl_rdata} :
               (addr == flash_seq_pkg::REG_CMD) ? {8'h00, pattern} : 16'h0000;
    else
      rdata <= '0;
  end
endmodule
`default_nettype wire

// [core/flash_sequencer.sv]
// Flash self-program sequencer: page buffer, erase and write timing, CPU halt.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module flash_sequencer #(
  parameter int WORD_W = 5,
  parameter int PAGE_W = 6,
  parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // CPU side.
  flash_seq_if.device bus,
  // EEPROM activity.
  input wire logic eeprom_busy,
  input wire logic eeprom_write,
  // Flash array side.
  output logic flash_erase,
  output logic flash_write,
  output logic [PAGE_W-1:0] flash_page,
  output logic [15:0] flash_wdata,
  output logic [WORD_W-1:0] flash_word,
  output logic flash_word_we
);
  localparam int DEPTH = 1 << WORD_W;
  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } state_t;

  state_t state;
  state_t next_state;
  logic [7:0] ctrl;
  logic [2:0] arm_age;
  logic [CNT_W-1:0] op_count;
  logic [15:0] buffer [DEPTH];
  logic [DEPTH-1:0] loaded;
  logic [PAGE_W-1:0] op_page;

  // Decode of the CPU command and the armed pattern.
  wire ctrl_accept = bus.ctrl_we && !eeprom_busy && state == ST_IDLE;
  wire armed = ctrl[flash_seq_pkg::PROGRAM_ENABLE_POS] && arm_age < 3'(flash_seq_pkg::ARM_WINDOW);
  wire [7:0] armed_pat = ctrl & flash_seq_pkg::CTRL_MASK;
  wire do_store = bus.spm_strobe && armed && state == ST_IDLE;
  wire do_load = do_store && armed_pat == flash_seq_pkg::PAT_LOAD;
  wire do_erase = do_store && armed_pat == flash_seq_pkg::PAT_ERASE;
  wire do_write = do_store && armed_pat == flash_seq_pkg::PAT_WRITE;
  wire [WORD_W-1:0] word_idx = bus.pointer[WORD_W-1:0];
  wire [PAGE_W-1:0] page_idx = bus.pointer[WORD_W +: PAGE_W];
  wire op_done = state != ST_IDLE && op_count == CNT_W'(OP_CYCLES - 1);
  wire clear_req = bus.ctrl_we && bus.ctrl_wdata[flash_seq_pkg::CLEAR_BUFFER_POS];
  wire write_done = state == ST_WRITE && op_done;
  wire buf_clear = write_done || clear_req || eeprom_write;
  wire [WORD_W-1:0] stream_idx = WORD_W'(op_count);

  // Next state of the operation sequencer.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (do_erase)
          next_state = ST_ERASE;
        else if (do_write)
          next_state = ST_WRITE;
      end
      ST_ERASE, ST_WRITE:
      begin
        if (op_done)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State and operation timer.
  // timed operation
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      op_count <= '0;
    end
    else
    begin
      state <= next_state;
      op_count <= (state == ST_IDLE || op_done) ? '0 : op_count + 1'b1;
    end
  end

  // Control register; the clear-buffer bit is a one-shot and never stored.
  // EEPROM blocks writes
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrl <= flash_seq_pkg::CTRL_RESET;
      arm_age <= '0;
    end
    else if (ctrl_accept)
    begin
      ctrl <= bus.ctrl_wdata & 8'h07;
      arm_age <= '0;
    end
    else if ((ctrl[flash_seq_pkg::PROGRAM_ENABLE_POS] && !armed) || do_load || op_done)
    begin
      ctrl <= flash_seq_pkg::CTRL_RESET;
      arm_age <= '0;
    end
    // The window age freezes once a store is taken, so the bits stand until completion.
    else if (ctrl[flash_seq_pkg::PROGRAM_ENABLE_POS] && state == ST_IDLE && !do_store)
      arm_age <= arm_age + 1'b1;
  end

  // Page captured at the start of an erase or a write; data pair ignored.
  // page only
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      op_page <= '0;
    else if (do_erase || do_write)
      op_page <= page_idx;
  end

  // Valid-word marks; an unloaded word programs as erased all-ones.
  // A word loaded in the same cycle as a clear survives it: the set wins.
  wire [DEPTH-1:0] load_mark = do_load ? (DEPTH'(1) << word_idx) : '0;
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      loaded <= '0;
    else
      loaded <= (buf_clear ? '0 : loaded) | load_mark;
  end

  always_ff @(posedge mclk)
  begin
    if (do_load)
      buffer[word_idx] <= bus.data_pair;
  end

  // Flash array strobes; write streams the buffer one word per cycle.
  // erase start
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page <= '0;
      flash_word <= '0;
      flash_wdata <= '0;
      flash_word_we <= 1'b0;
    end
    else
    begin
      flash_erase <= next_state == ST_ERASE;
      flash_write <= next_state == ST_WRITE;
      flash_page <= (do_erase || do_write) ? page_idx : op_page;
      flash_word_we <= state == ST_WRITE && op_count < CNT_W'(DEPTH);
      flash_word <= stream_idx;
      flash_wdata <= loaded[stream_idx] ? buffer[stream_idx] : 16'hFFFF;
    end
  end

  // Halt and readback, both registered.
  // halt erase
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      bus.cpu_halt <= 1'b0;
      bus.ctrl_rdata <= '0;
    end
    else
    begin
      bus.cpu_halt <= next_state != ST_IDLE;
      bus.ctrl_rdata <= ctrl;
    end
  end
endmodule
`default_nettype wire

// [verification/flash_seq_sva.sv]
// Checker for the CPU link of the flash sequencer.
`timescale 1ns/100ps
`default_nettype none
module flash_seq_sva #(
  parameter int OP_CYCLES = 40
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Link and EEPROM signals.
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic spm_strobe,
  input wire logic cpu_halt,
  input wire logic eeprom_busy
);
  logic [15:0] hcnt;
  // Halt length counter, since a repetition this long would choke the tools.
  always_ff @(posedge mclk)
    hcnt <= (rst_b && cpu_halt) ? hcnt + 16'h0001 : 16'h0000;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_erase; ctrl_we && !eeprom_busy && !cpu_halt && ctrl_wdata == 8'h03
    ##1 spm_strobe |=> cpu_halt; endproperty
  a_erase: assert property (p_erase) else $error("Erase did not halt.");
  property p_write; ctrl_we && !eeprom_busy && !cpu_halt && ctrl_wdata == 8'h05
    ##1 spm_strobe |=> cpu_halt; endproperty
  a_write: assert property (p_write) else $error("Write did not halt.");
  property p_load; ctrl_we && ctrl_wdata == 8'h01 ##1 spm_strobe |=> !cpu_halt; endproperty
  a_load: assert property (p_load) else $error("Load halted.");
  property p_busy; ctrl_we && eeprom_busy && !cpu_halt ##1 spm_strobe |=> !cpu_halt; endproperty
  a_busy: assert property (p_busy) else $error("Busy did not block.");
  property p_cause; $rose(cpu_halt) |-> $past(spm_strobe); endproperty
  a_cause: assert property (p_cause) else $error("Halt without store.");
  property p_len; $fell(cpu_halt) |-> hcnt == 16'(OP_CYCLES); endproperty
  a_len: assert property (p_len) else $error("Wrong operation length.");
  property p_cap; hcnt <= 16'(OP_CYCLES); endproperty
  a_cap: assert property (p_cap) else $error("Halt too long.");
  property p_clr; $fell(cpu_halt) |-> ##[0:1] ctrl_rdata[2:0] == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("Control bits stuck.");
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the CPU end and flash sequencer pair.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk, rst_b, wr, rd, eeprom_busy, eeprom_write, flash_erase, flash_write, flash_word_we, erase_d;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, flash_wdata, st;
  logic [5:0] flash_page;
  logic [4:0] flash_word;
  logic [15:0] page_model [0:31];
  logic [27:0] exp_q [$];
  int error_cnt, cmp_count;
  integer seed;
  flash_seq_if link ();
  flash_cpu_end flash_cpu_end_inst (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bus(link.cpu));
  flash_sequencer #(.WORD_W(5), .PAGE_W(6), .OP_CYCLES(40)) flash_sequencer_inst (.mclk(mclk), .rst_b(rst_b),
    .bus(link.device), .eeprom_busy(eeprom_busy), .eeprom_write(eeprom_write), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page), .flash_wdata(flash_wdata), .flash_word(flash_word),
    .flash_word_we(flash_word_we));
  flash_seq_sva #(.OP_CYCLES(40)) flash_seq_sva_inst (.mclk(mclk), .rst_b(rst_b), .ctrl_we(link.ctrl_we),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .spm_strobe(link.spm_strobe),
    .cpu_halt(link.cpu_halt), .eeprom_busy(eeprom_busy));
  // Reports and counts one comparison.
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whatever wipes the buffer leaves every word of the next page erased.
  task automatic blank_model();
    for (int i = 0; i < 32; i++)
      page_model[i] = 16'hFFFF;
  endtask
  // Register port cycles; offsets 0 to 3 are command, pointer, data, status.
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 st = rdata;
  endtask
  // Issues a command, then polls busy under a bound so a hang is caught.
  task automatic cmd(input logic [1:0] c);
    int n;
    reg_wr(4'h0, {14'h0000, c});
    repeat (3) @(posedge mclk);
    n = 0;
    st = 16'hFFFF;
    while (st[8] !== 1'b0 && n < 200)
    begin
      reg_rd(4'h3);
      n++;
    end
    check({31'h0, st[8]}, 32'h0);
  endtask
  // Loads six distinct words out of order with random data.
  task automatic fill(input logic [5:0] p);
    logic [15:0] d;
    for (int k = 0; k < 6; k++)
    begin
      d = 16'($random(seed));
      reg_wr(4'h1, {5'h00, p, 5'((k * 13 + 5) % 32)});
      reg_wr(4'h2, d);
      cmd(flash_seq_pkg::CMD_LOAD);
      page_model[(k * 13 + 5) % 32] = d;
    end
  endtask
  task automatic erase_page(input logic [5:0] p);
    reg_wr(4'h1, {5'h00, p, 5'($random(seed))});
    reg_wr(4'h2, 16'($random(seed)));
    exp_q.push_back({1'b1, p, 21'h000000});
    cmd(flash_seq_pkg::CMD_ERASE);
  endtask
  // Every word of the page is expected in order, unloaded ones erased.
  task automatic write_page(input logic [5:0] p);
    reg_wr(4'h1, {5'h00, p, 5'h00});
    for (int i = 0; i < 32; i++)
    begin
      exp_q.push_back({1'b0, p, 5'(i), page_model[i]});
      page_model[i] = 16'hFFFF;
    end
    cmd(flash_seq_pkg::CMD_WRITE);
    check(32'(exp_q.size()), 32'h0);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Each erase start or streamed word takes the oldest note.
  always @(posedge mclk)
  begin
    erase_d <= flash_erase;
    if (rst_b === 1'b1 && (flash_word_we === 1'b1 || (flash_erase === 1'b1 && erase_d !== 1'b1)))
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check({4'h0, flash_erase, flash_page, flash_erase ? 21'h0 : {flash_word, flash_wdata}}, {4'h0, exp_q.pop_front()});
    end
  end
  initial
  begin
    #3000000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    seed = 32'h0ade;
    {rst_b, wr, rd, eeprom_busy, eeprom_write, addr, wdata} <= '0;
    blank_model();
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    fill(6'h05);
    erase_page(6'h05);
    write_page(6'h05);
    erase_page(6'h3F);
    fill(6'h3F);
    write_page(6'h3F);
    fill(6'h01);
    cmd(flash_seq_pkg::CMD_CLEAR);
    blank_model();
    erase_page(6'h01);
    write_page(6'h01);
    fill(6'h02);
    @(posedge mclk) eeprom_write <= 1'b1;
    @(posedge mclk) eeprom_write <= 1'b0;
    blank_model();
    erase_page(6'h02);
    write_page(6'h02);
    fill(6'h03);
    @(posedge mclk) rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    blank_model();
    erase_page(6'h03);
    write_page(6'h03);
    @(posedge mclk) eeprom_busy <= 1'b1;
    cmd(flash_seq_pkg::CMD_ERASE);
    @(posedge mclk) eeprom_busy <= 1'b0;
    reg_rd(4'h3);
    check({16'h0000, st}, 32'h0);
    reg_rd(4'hF);
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule
`default_nettype wire
